// *** src/rcf_reset_cause_flags.sv ***
// reset cause flags, working register guard and segment guard
//
// Decided for this implementation: the register addresses and the APB register port.

// Notes on behaviour
// - unwritten working register pointer use resets
// - resets clear working registers except stack
// - flow change into protected segment resets
// - branch kinds count as program flow change
// - vector load counts as vector flow change
// - bit 15 trap conflict, cleared power resets
// - bit 14 illegal, uninit or security
// - bit 9 config mismatch, cleared power resets
// - bit 7 pin reset, of the resets only power-on clears, software write can too
// - bit 6 reset instruction, power resets clear
// - bit 4 watchdog, several clears listed
// - bit 3 sleep selected by power save
// - bit 2 idle selected by power save
// - bit 1 power-on or brown-out, hardware never clears, software write can
// - bit 0 power-on only, hardware never clears, software write can
// - software may set or clear flags
module rcf_reset_cause_flags
	import rcf_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// external reset pin, active low, asynchronous
	input wire logic external_reset_pin_n,
	// reset events from the core, one-cycle pulses
	input wire logic brownout_reset,
	input wire logic trapConflict,
	input wire logic illegalOpcode,
	input wire logic configMismatch,
	input wire logic softResetInstr,
	input wire logic watchdogTimeout,
	input wire logic watchdog_clear_instruction,
	input wire logic power_save_instruction,
	input wire logic powerSaveSleep,
	// working register traffic
	input wire logic wregWrite,
	input wire logic [3:0] wregWriteIdx,
	input wire logic ptrUse,
	input wire logic [3:0] ptrUseIdx,
	// program counter reloads
	input wire logic pcLoad,
	input wire logic [2:0] pcLoadKind,
	input wire logic [23:0] pcTarget,
	// results
	output logic uninitResetReq,
	output logic securityResetReq,
	output logic [15:0] reset_cause_status
);
	timeunit 1ns;
	timeprecision 1ps;

	// =========================================================
	// decoding functions

	// address match against one register offset
	function automatic logic regHit(
		input logic [7:0] addr,
		input logic [7:0] off
	);
		regHit = (addr == off);
	endfunction

	// target inside the protected window
	function automatic logic inProtected(
		input logic [23:0] target,
		input logic [23:0] lo,
		input logic [23:0] hi,
		input logic en
	);
		inProtected = en && (target >= lo) && (target <= hi);
	endfunction

	// =========================================================
	// state declarations

	logic [2:0] pinSync;
	logic pinLevel;
	logic next_pinLevel;
	logic pinEvent;
	logic [RCF_NUM_WREG-1:0] wregInit;
	logic [RCF_NUM_WREG-1:0] next_wregInit;
	logic [23:0] protLo;
	logic [23:0] protHi;
	logic protEn;
	logic [23:0] next_protLo;
	logic [23:0] next_protHi;
	logic next_protEn;
	logic [15:0] next_cause;
	logic next_uninitResetReq;
	logic next_securityResetReq;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic busWrite;
	logic accessPhase;
	logic mapped;
	logic program_flow_change;
	logic vector_flow_change;
	logic uninitHit;
	logic securityHit;
	logic anyReset;

	// =========================================================
	// external reset pin synchroniser

	// three flops, level accepted once the last two agree
	always_comb begin
		next_pinLevel = pinLevel;
		if (pinSync[1] == pinSync[2]) begin
			next_pinLevel = pinSync[2];
		end
	end

	// falling edge of the accepted level is the pin reset
	assign pinEvent = pinLevel && !next_pinLevel;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinSync <= 3'h7;
			pinLevel <= 1'b1;
		end else begin
			pinSync <= {pinSync[1:0], external_reset_pin_n};
			pinLevel <= next_pinLevel;
		end
	end

	// =========================================================
	// fault detection

	// program flow change: any branch style reload
	always_comb begin
		program_flow_change = 1'b0;
		vector_flow_change = 1'b0;
		if (pcLoad) begin
			case (pcLoadKind)
				RCF_PC_CALL,
				RCF_PC_JUMP,
				RCF_PC_CJUMP,
				RCF_PC_RETURN,
				RCF_PC_RETSUB,
				RCF_PC_BRANCH: begin
					program_flow_change = 1'b1;
				end
				RCF_PC_VECTOR: begin
					vector_flow_change = 1'b1;
				end
				default: begin
					program_flow_change = 1'b0;
					vector_flow_change = 1'b0;
				end
			endcase
		end
	end

	// flow change into the guarded segment
	assign securityHit = (program_flow_change || vector_flow_change) &&
		inProtected(pcTarget, protLo, protHi, protEn);

	// pointer use of a register not written since reset
	assign uninitHit = ptrUse && !wregInit[ptrUseIdx];

	// every reset kind, used to wipe the working registers
	assign anyReset = brownout_reset || pinEvent || trapConflict ||
		illegalOpcode || configMismatch || softResetInstr ||
		watchdogTimeout || uninitHit || securityHit;

	// =========================================================
	// working register initialised bits

	// one bit per register, stack register always counts as written
	generate
		for (genvar i = 0; i < RCF_NUM_WREG; i++) begin : g_wreg
			if (i == int'(RCF_STACK_REG)) begin : g_stack
				assign next_wregInit[i] = 1'b1;
			end else begin : g_work
				always_comb begin
					next_wregInit[i] = wregInit[i];
					if (anyReset) begin
						next_wregInit[i] = 1'b0;
					end else if (wregWrite &&
						wregWriteIdx == 4'(i)) begin
						next_wregInit[i] = 1'b1;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wregInit <= RCF_WREG_RST;
		end else begin
			wregInit <= next_wregInit;
		end
	end

	// =========================================================
	// reset requests towards the reset controller

	always_comb begin
		next_uninitResetReq = uninitHit;
		next_securityResetReq = securityHit;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			uninitResetReq <= 1'b0;
			securityResetReq <= 1'b0;
		end else begin
			uninitResetReq <= next_uninitResetReq;
			securityResetReq <= next_securityResetReq;
		end
	end

	// =========================================================
	// apb slave

	// write commits only at the edge that sees pready high
	assign accessPhase = psel && penable;
	assign busWrite = accessPhase && pready && pwrite;
	assign mapped = regHit(paddr, RCF_CAUSE_OFF) ||
		regHit(paddr, RCF_PROT_LO_OFF) ||
		regHit(paddr, RCF_PROT_HI_OFF) ||
		regHit(paddr, RCF_PROT_CTRL_OFF) ||
		regHit(paddr, RCF_INIT_STAT_OFF);

	// one wait state, read data captured with pready
	always_comb begin
		next_pready = accessPhase && !pready;
		next_pslverr = accessPhase && !pready && !mapped;
		next_prdata = 32'h00000000;
		if (accessPhase && !pready && !pwrite) begin
			if (regHit(paddr, RCF_CAUSE_OFF)) begin
				next_prdata = {16'h0000, reset_cause_status};
			end else if (regHit(paddr, RCF_PROT_LO_OFF)) begin
				next_prdata = {8'h00, protLo};
			end else if (regHit(paddr, RCF_PROT_HI_OFF)) begin
				next_prdata = {8'h00, protHi};
			end else if (regHit(paddr, RCF_PROT_CTRL_OFF)) begin
				next_prdata = {31'h00000000, protEn};
			end else if (regHit(paddr, RCF_INIT_STAT_OFF)) begin
				next_prdata = {16'h0000, wregInit};
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

	// =========================================================
	// protected segment configuration

	always_comb begin
		next_protLo = protLo;
		next_protHi = protHi;
		next_protEn = protEn;
		if (busWrite && regHit(paddr, RCF_PROT_LO_OFF)) begin
			next_protLo = pwdata[23:0];
		end
		if (busWrite && regHit(paddr, RCF_PROT_HI_OFF)) begin
			next_protHi = pwdata[23:0];
		end
		if (busWrite && regHit(paddr, RCF_PROT_CTRL_OFF)) begin
			next_protEn = pwdata[RCF_PROT_EN_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			protLo <= RCF_PROT_LO_RST;
			protHi <= RCF_PROT_HI_RST;
			protEn <= RCF_PROT_EN_RST;
		end else begin
			protLo <= next_protLo;
			protHi <= next_protHi;
			protEn <= next_protEn;
		end
	end

	// =========================================================
	// reset cause flags

	// order: software write, hardware clears, hardware sets
	always_comb begin
		next_cause = reset_cause_status;
		if (busWrite && regHit(paddr, RCF_CAUSE_OFF)) begin
			next_cause = pwdata[15:0] & RCF_CAUSE_MASK;
		end
		// brown-out wipes all but pin, brown-out and power-on
		if (brownout_reset) begin
			next_cause = next_cause & RCF_BOR_KEEP;
		end
		if (power_save_instruction || watchdog_clear_instruction) begin
			next_cause[RCF_WDT_BIT] = 1'b0;
		end
		// sets win over any clear in the same cycle
		if (trapConflict) begin
			next_cause[RCF_TRAP_BIT] = 1'b1;
		end
		if (illegalOpcode || uninitHit || securityHit) begin
			next_cause[RCF_ILLEGAL_BIT] = 1'b1;
		end
		if (configMismatch) begin
			next_cause[RCF_CM_BIT] = 1'b1;
		end
		if (pinEvent) begin
			next_cause[RCF_PIN_BIT] = 1'b1;
		end
		if (softResetInstr) begin
			next_cause[RCF_SOFT_BIT] = 1'b1;
		end
		if (watchdogTimeout) begin
			next_cause[RCF_WDT_BIT] = 1'b1;
		end
		if (power_save_instruction && powerSaveSleep) begin
			next_cause[RCF_SLEEP_BIT] = 1'b1;
		end
		if (power_save_instruction && !powerSaveSleep) begin
			next_cause[RCF_IDLE_BIT] = 1'b1;
		end
		if (brownout_reset) begin
			next_cause[RCF_BOR_BIT] = 1'b1;
		end
		// unimplemented bits always read zero
		next_cause = next_cause & RCF_CAUSE_MASK;
	end

	// power-on reset: only the two power flags stand set
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_cause_status <= RCF_CAUSE_RST;
		end else begin
			reset_cause_status <= next_cause;
		end
	end

endmodule

// *** src/rcf_pkg.sv ***
// package of constants for the reset cause flag block
package rcf_pkg;
	timeunit 1ns;
	timeprecision 1ps;

	// =========================================================
	// register map, byte addresses on the apb bus
	localparam logic [7:0] RCF_CAUSE_OFF = 8'h00;
	localparam logic [7:0] RCF_PROT_LO_OFF = 8'h04;
	localparam logic [7:0] RCF_PROT_HI_OFF = 8'h08;
	localparam logic [7:0] RCF_PROT_CTRL_OFF = 8'h0c;
	localparam logic [7:0] RCF_INIT_STAT_OFF = 8'h10;

	// =========================================================
	// flag positions inside reset_cause_status, and the enable bit of the protection control register
	localparam int RCF_TRAP_BIT = 15;
	localparam int RCF_ILLEGAL_BIT = 14;
	localparam int RCF_CM_BIT = 9;
	localparam int RCF_PIN_BIT = 7;
	localparam int RCF_SOFT_BIT = 6;
	localparam int RCF_WDT_BIT = 4;
	localparam int RCF_SLEEP_BIT = 3;
	localparam int RCF_IDLE_BIT = 2;
	localparam int RCF_BOR_BIT = 1;
	localparam int RCF_POR_BIT = 0;
	localparam int RCF_PROT_EN_BIT = 0;

	// =========================================================
	// widths, masks and reset values
	localparam int RCF_CAUSE_W = 16;
	localparam int RCF_ADDR_W = 24;
	localparam int RCF_NUM_WREG = 16;
	localparam logic [3:0] RCF_STACK_REG = 4'hf;
	localparam logic [15:0] RCF_CAUSE_MASK = 16'hc2df;
	localparam logic [15:0] RCF_BOR_KEEP = 16'h0083;
	localparam logic [15:0] RCF_CAUSE_RST = 16'h0003;
	localparam logic [15:0] RCF_WREG_RST = 16'h8000;
	localparam logic [23:0] RCF_PROT_LO_RST = 24'h000000;
	localparam logic [23:0] RCF_PROT_HI_RST = 24'h000000;
	localparam logic RCF_PROT_EN_RST = 1'b0;

	// =========================================================
	// kinds of program counter reload
	localparam logic [2:0] RCF_PC_CALL = 3'h0;
	localparam logic [2:0] RCF_PC_JUMP = 3'h1;
	localparam logic [2:0] RCF_PC_CJUMP = 3'h2;
	localparam logic [2:0] RCF_PC_RETURN = 3'h3;
	localparam logic [2:0] RCF_PC_RETSUB = 3'h4;
	localparam logic [2:0] RCF_PC_BRANCH = 3'h5;
	localparam logic [2:0] RCF_PC_VECTOR = 3'h6;

endpackage

// *** tb/rcf_checker.sv ***
// checker of the reset cause flag block
module rcf_checker
	import rcf_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic brownout_reset,
	input wire logic trapConflict,
	input wire logic illegalOpcode,
	input wire logic configMismatch,
	input wire logic softResetInstr,
	input wire logic watchdogTimeout,
	input wire logic power_save_instruction,
	input wire logic powerSaveSleep,
	input wire logic ptrUse,
	input wire logic [3:0] ptrUseIdx,
	input wire logic uninitResetReq,
	input wire logic securityResetReq,
	input wire logic [15:0] reset_cause_status
);
	timeunit 1ns;
	timeprecision 1ps;
	// =========================================================
	// clock and reset for all properties
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// =========================================================
	// flag setting and keeping
	a_trap_sets: assert property (
		trapConflict |=> reset_cause_status[15])
		else $error("trap flag not set");
	a_illegal_sets: assert property (
		illegalOpcode |=> reset_cause_status[14])
		else $error("illegal flag not set");
	a_cm_sets: assert property (
		configMismatch |=> reset_cause_status[9])
		else $error("mismatch flag not set");
	a_soft_sets: assert property (
		softResetInstr |=> reset_cause_status[6])
		else $error("soft reset flag not set");
	a_wdt_sets: assert property (
		watchdogTimeout |=> reset_cause_status[4])
		else $error("watchdog flag not set");
	a_sleep_sets: assert property (
		power_save_instruction && powerSaveSleep && !watchdogTimeout
		|=> reset_cause_status[3] && !reset_cause_status[4])
		else $error("sleep flag wrong");
	a_idle_sets: assert property (
		power_save_instruction && !powerSaveSleep
		|=> reset_cause_status[2])
		else $error("idle flag not set");
	a_bor_sets: assert property (
		brownout_reset && !trapConflict
		|=> reset_cause_status[1] && !reset_cause_status[15])
		else $error("brown-out flags wrong");
	a_pin_kept: assert property (
		brownout_reset && !pready && reset_cause_status[7]
		|=> reset_cause_status[7])
		else $error("pin flag lost on brown-out");
	a_req_flag: assert property (
		uninitResetReq || securityResetReq |-> reset_cause_status[14])
		else $error("reset request without flag");
	a_stack_safe: assert property (
		ptrUse && ptrUseIdx == RCF_STACK_REG |=> !uninitResetReq)
		else $error("stack register treated as unwritten");
	// =========================================================
	// bus answer
	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered after one wait");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule

bind rcf_reset_cause_flags rcf_checker i_chk(.core_clk, .rst_n, .psel,
	.penable, .pready, .pslverr, .brownout_reset, .trapConflict,
	.illegalOpcode, .configMismatch, .softResetInstr, .watchdogTimeout,
	.power_save_instruction, .powerSaveSleep, .ptrUse, .ptrUseIdx,
	.uninitResetReq, .securityResetReq, .reset_cause_status);

// *** tb/tb_reset_cause_flags.sv ***
// testbench of the reset cause flag block
module tb_reset_cause_flags
	import rcf_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic pready, pslverr, e, r, pin_n = 1, bor = 0, trp = 0, ill = 0;
	logic cm = 0, sw = 0, wdt = 0, clr = 0, ps = 0, slp = 0, wrW = 0;
	logic ptr = 0, pc = 0, uReq, sReq;
	logic [3:0] wIdx = 0, pIdx = 0;
	logic [2:0] kind = 0;
	logic [23:0] tgt = 0;
	logic [15:0] cause;
	int failures = 0, cmp_count = 0, i;
	logic [15:0] expBit [7] = '{16'h8000, 16'h4000, 16'h0200, 16'h0040,
		16'h0010, 16'h0008, 16'h0004};
	// =========================================================
	// clock and device
	always #5 core_clk = ~core_clk;
	rcf_reset_cause_flags i_dut(.core_clk, .rst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr,
		.external_reset_pin_n(pin_n), .brownout_reset(bor),
		.trapConflict(trp), .illegalOpcode(ill), .configMismatch(cm),
		.softResetInstr(sw), .watchdogTimeout(wdt),
		.watchdog_clear_instruction(clr), .power_save_instruction(ps),
		.powerSaveSleep(slp), .wregWrite(wrW), .wregWriteIdx(wIdx),
		.ptrUse(ptr), .ptrUseIdx(pIdx), .pcLoad(pc), .pcLoadKind(kind),
		.pcTarget(tgt), .uninitResetReq(uReq), .securityResetReq(sReq),
		.reset_cause_status(cause));
	// =========================================================
	// reporting
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] x, input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			failures++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, x, g);
		end
	endtask
	// =========================================================
	// apb transfer, result left in q and e
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			tally_and_finish;
		end
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// =========================================================
	// one-cycle event pulses
	task drv(input int k, input logic v);
		case (k)
			0: trp <= v;
			1: ill <= v;
			2: cm <= v;
			3: sw <= v;
			4: wdt <= v;
			5, 6: ps <= v;
			7: bor <= v;
			default: clr <= v;
		endcase
		slp <= (k == 5);
	endtask
	task ev(input int k);
		@(posedge core_clk);
		drv(k, 1);
		@(posedge core_clk);
		drv(k, 0);
	endtask
	// pointer use or pc load, r takes the request output
	task probe(input logic isPc, input logic [2:0] k, input logic [23:0] t);
		@(posedge core_clk);
		ptr <= !isPc;
		pc <= isPc;
		kind <= k;
		tgt <= t;
		pIdx <= t[3:0];
		@(posedge core_clk);
		ptr <= 0;
		pc <= 0;
		#1 r = isPc ? sReq : uReq;
	endtask
	// =========================================================
	// main sequence
	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1;
		xfer(0, RCF_CAUSE_OFF, 0);
		chk(32'h3, q);
		xfer(1, RCF_CAUSE_OFF, 32'hffffffff);
		xfer(0, RCF_CAUSE_OFF, 0);
		chk(32'hc2df, q);
		for (i = 0; i < 7; i++) begin
			xfer(1, RCF_CAUSE_OFF, 0);
			ev(i);
			xfer(0, RCF_CAUSE_OFF, 0);
			chk({16'h0, expBit[i]}, q);
		end
		xfer(1, RCF_CAUSE_OFF, 0);
		@(posedge core_clk);
		pin_n <= 0;
		repeat (6) @(posedge core_clk);
		pin_n <= 1;
		ev(3);
		xfer(0, RCF_CAUSE_OFF, 0);
		chk(32'hc0, q);
		ev(7);
		xfer(0, RCF_CAUSE_OFF, 0);
		chk(32'h82, q);
		ev(4);
		ev(8);
		xfer(0, RCF_CAUSE_OFF, 0);
		chk(32'h82, q);
		ev(4);
		ev(5);
		xfer(0, RCF_CAUSE_OFF, 0);
		chk(32'h8a, q);
		@(posedge core_clk);
		wrW <= 1;
		wIdx <= 4'h3;
		@(posedge core_clk);
		wrW <= 0;
		probe(0, 0, 24'h3);
		chk(32'h0, {31'h0, r});
		probe(0, 0, 24'hf);
		chk(32'h0, {31'h0, r});
		probe(0, 0, 24'h5);
		chk(32'h1, {31'h0, r});
		xfer(0, RCF_INIT_STAT_OFF, 0);
		chk(32'h8000, q);
		xfer(1, RCF_PROT_LO_OFF, 32'h100);
		xfer(1, RCF_PROT_HI_OFF, 32'h1ff);
		probe(1, RCF_PC_JUMP, 24'h1ff);
		chk(32'h0, {31'h0, r});
		xfer(1, RCF_PROT_CTRL_OFF, 32'h1);
		for (i = 0; i < 7; i++) begin
			probe(1, i[2:0], 24'h1ff);
			chk(32'h1, {31'h0, r});
		end
		probe(1, 3'h7, 24'h1ff);
		chk(32'h0, {31'h0, r});
		probe(1, RCF_PC_VECTOR, 24'h200);
		chk(32'h0, {31'h0, r});
		xfer(0, RCF_CAUSE_OFF, 0);
		chk(32'h4000, {16'h0, q[15:0] & 16'h4000});
		xfer(0, 8'h20, 0);
		chk(32'h1, {31'h0, e});
		@(posedge core_clk);
		rst_n <= 0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1;
		xfer(0, RCF_CAUSE_OFF, 0);
		chk(32'h3, q);
		tally_and_finish;
	end
endmodule
